// ### rtl/lio_pkg.sv
// Constants, types and register map of the logical signal bank.
//
// How it works
// - Thirty-two logical outputs carry binary values produced by user logic.
// - Each output value is available to functions, groups, relays and indicators.
// - Software can read the present state of every logical output.
// - Thirty-two logical inputs follow set and clear commands from mimic or software.
// - Every logical input is zero after any restart of the device.
// - A hold-mode input goes to one on set, stays until clear or restart.
// - A pulse-mode input goes to one on set, returns to zero after 5 ms.
// - Every logical input has its own hold or pulse mode bit.
// - Rising changes make ON events and falling changes make OFF events.
// - Enable bits choose ON, OFF or both events; others are discarded.
// - Each event carries a time stamp and its group identifier.
// - A falling-edge delay lets an output outlast the 5 ms input pulse.
package lio_pkg;
    // Bank size and timing.
    localparam int LIO_N        = 32;
    localparam int LIO_EV_N     = 4 * LIO_N;
    localparam int LIO_CLK_NS   = 100;
    localparam int LIO_MS_NS    = 1000000;
    localparam int LIO_MS_CYC   = (LIO_MS_NS + LIO_CLK_NS - 1) / LIO_CLK_NS;
    localparam int LIO_PULSE_MS = 5;
    localparam int LIO_PRE_W    = 14;

    // Register offsets, byte addresses of 32-bit words.
    localparam logic [7:0] LIO_OFS_LO_STAT  = 8'h00;
    localparam logic [7:0] LIO_OFS_LI_STAT  = 8'h04;
    localparam logic [7:0] LIO_OFS_LI_MODE  = 8'h08;
    localparam logic [7:0] LIO_OFS_LI_SET   = 8'h0c;
    localparam logic [7:0] LIO_OFS_LI_CLR   = 8'h10;
    localparam logic [7:0] LIO_OFS_EVT_CFG  = 8'h14;
    localparam logic [7:0] LIO_OFS_DLY_EN   = 8'h18;
    localparam logic [7:0] LIO_OFS_DLY_MS   = 8'h1c;
    localparam logic [7:0] LIO_OFS_IRQ_STAT = 8'h20;
    localparam logic [7:0] LIO_OFS_IRQ_MASK = 8'h24;
    localparam logic [7:0] LIO_OFS_TSTAMP   = 8'h28;

    // Field positions.
    localparam int LIO_CFG_ON  = 0;
    localparam int LIO_CFG_OFF = 1;
    localparam int LIO_IRQ_OUT = 0;
    localparam int LIO_IRQ_IN  = 1;

    // Reset values.
    localparam logic [31:0] LIO_MODE_RST  = 32'h0000_0000;
    localparam logic [31:0] LIO_DLYEN_RST = 32'h0000_0000;
    localparam logic [1:0]  LIO_CFG_RST   = 2'h3;
    localparam logic [15:0] LIO_DLY_RST   = 16'h0000;
    localparam logic [1:0]  LIO_MASK_RST  = 2'h0;

    // Event group identifier.
    typedef enum logic {
        output_event_group = 1'b0,
        input_event_group  = 1'b1
    } lio_grp_e;

    // Register port request.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } lio_bus_s;

    // Mimic switch commands, one bit per logical input.
    typedef struct packed {
        logic [31:0] set;
        logic [31:0] clr;
    } lio_cmd_s;

    // Event towards the main event buffer.
    typedef struct packed {
        logic        valid;
        lio_grp_e    grp;
        logic [4:0]  idx;
        logic        on;
        logic [31:0] stamp;
    } lio_evt_s;
endpackage

// ### rtl/lio_in_cell.sv
// One logical input with hold and pulse behaviour.
`timescale 1ns/10ps
`default_nettype none
module lio_in_cell #(
    parameter int unsigned MS_CYCLES = lio_pkg::LIO_MS_CYC
) (
    // Clock and reset.
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Commands and mode.
    input  wire logic i_set,
    input  wire logic i_clr,
    input  wire logic i_pulse,
    // State.
    output logic      o_state
);
    import lio_pkg::*;

    logic [LIO_PRE_W-1:0] pre_r;
    logic [2:0]           ms_r;
    logic                 state_r;
    logic [LIO_PRE_W-1:0] pre_nxt;
    logic [2:0]           ms_nxt;
    logic                 state_nxt;
    wire                  busy;
    wire                  pre_end;
    wire                  pulse_end;
    int                   hi_cnt;

    // A pulse runs while the input is high in pulse mode.
    assign busy      = state_r & i_pulse;
    assign pre_end   = (pre_r == LIO_PRE_W'(MS_CYCLES - 1));
    assign pulse_end = busy & pre_end & (ms_r == 3'(LIO_PULSE_MS - 1));

    // Set wins over clear; a set restarts the millisecond divider.
    assign state_nxt = i_set ? 1'b1 : ((i_clr | pulse_end) ? 1'b0 : state_r);
    assign pre_nxt   = (i_set | ~busy | pre_end) ? '0 : pre_r + 1'b1;
    assign ms_nxt    = (i_set | ~busy) ? 3'h0 : (pre_end ? ms_r + 3'h1 : ms_r);

    // State and timers; reset clears the input.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= 1'b0;
            pre_r   <= '0;
            ms_r    <= 3'h0;
        end else begin
            state_r <= state_nxt;
            pre_r   <= pre_nxt;
            ms_r    <= ms_nxt;
        end
    end

    assign o_state = state_r;

    // Cycles spent high in one pulse, for checking only.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hi_cnt <= 0;
        end else begin
            hi_cnt <= (i_set | ~busy) ? 0 : hi_cnt + 1;
        end
    end

    a_pulse_len:
    assert property (@(posedge i_clk) disable iff (i_rst)
        busy |-> hi_cnt < int'(MS_CYCLES) * LIO_PULSE_MS)
    else $error("pulse input stayed high too long");

    a_hold_keep:
    assert property (@(posedge i_clk) disable iff (i_rst)
        state_r && !i_pulse && !i_clr |=> state_r)
    else $error("hold input dropped without clear");
endmodule
`default_nettype wire

// ### rtl/lio_bank.sv
// Logical output and logical input bank with events and register port.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module lio_bank #(
    parameter int unsigned MS_CYCLES = lio_pkg::LIO_MS_CYC
) (
    // Clock and reset.
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    // Register port.
    input  wire lio_pkg::lio_bus_s i_bus,
    output logic [31:0]            o_rdata,
    // Logical outputs from user logic and towards consumers.
    input  wire logic [31:0]       i_lo_val,
    output logic [31:0]            o_lo_val,
    // Logical inputs from the mimic and towards user logic.
    input  wire lio_pkg::lio_cmd_s i_mimic,
    output logic [31:0]            o_li_val,
    // Events and interrupt.
    output lio_pkg::lio_evt_s      o_evt,
    output logic                   o_irq
);
    import lio_pkg::*;

    default clocking dclk @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // Lowest set bit of an event request vector.
    function automatic logic [6:0] first_set(input logic [LIO_EV_N-1:0] v);
        logic [6:0] idx;
        idx = 7'h0;
        for (int k = LIO_EV_N - 1; k >= 0; k--) begin
            if (v[k]) begin
                idx = 7'(k);
            end
        end
        return idx;
    endfunction

    // Software registers.
    logic [31:0]          mode_r;
    logic [1:0]           cfg_r;
    logic [31:0]          dlyen_r;
    logic [15:0]          dly_r;
    logic [1:0]           istat_r;
    logic [1:0]           imask_r;
    logic [31:0]          rdata_r;

    // Block state.
    logic [LIO_PRE_W-1:0] pre_r;
    logic [31:0]          stamp_r;
    logic [31:0]          lo_r;
    logic [31:0]          lo_prev_r;
    logic [31:0]          li_prev_r;
    logic [LIO_EV_N-1:0]  pend_r;
    lio_evt_s             evt_r;

    // Next values and decode.
    logic [31:0]          lo_nxt;
    logic [31:0]          li_val;
    logic [31:0]          li_set;
    logic [31:0]          li_clr;
    logic [31:0]          rd_word;
    logic [LIO_EV_N-1:0]  en_mask;
    logic [LIO_EV_N-1:0]  new_ev;
    logic [LIO_EV_N-1:0]  live;
    logic [LIO_EV_N-1:0]  clr_vec;
    logic [LIO_EV_N-1:0]  pend_nxt;
    logic [6:0]           sel_idx;
    logic [1:0]           ev_hit;
    logic [1:0]           istat_nxt;
    logic [31:0]          lo_chg;
    logic [31:0]          li_chg;
    wire                  ms_tick;
    wire                  ev_any;
    wire                  on_en;
    wire                  off_en;

    // Register write decode.
    wire wr_mode  = i_bus.wr && (i_bus.addr == LIO_OFS_LI_MODE);
    wire wr_set   = i_bus.wr && (i_bus.addr == LIO_OFS_LI_SET);
    wire wr_clr   = i_bus.wr && (i_bus.addr == LIO_OFS_LI_CLR);
    wire wr_cfg   = i_bus.wr && (i_bus.addr == LIO_OFS_EVT_CFG);
    wire wr_dlyen = i_bus.wr && (i_bus.addr == LIO_OFS_DLY_EN);
    wire wr_dly   = i_bus.wr && (i_bus.addr == LIO_OFS_DLY_MS);
    wire wr_istat = i_bus.wr && (i_bus.addr == LIO_OFS_IRQ_STAT);
    wire wr_imask = i_bus.wr && (i_bus.addr == LIO_OFS_IRQ_MASK);

    // Millisecond tick shared by the time stamp and the output delays.
    assign ms_tick = (pre_r == LIO_PRE_W'(MS_CYCLES - 1));

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pre_r   <= '0;
            stamp_r <= 32'h0000_0000;
        end else begin
            pre_r   <= ms_tick ? '0 : pre_r + 1'b1;
            stamp_r <= ms_tick ? stamp_r + 32'h1 : stamp_r;
        end
    end

    // Software registers; mode bits pick hold or pulse per input.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_r  <= LIO_MODE_RST;
            cfg_r   <= LIO_CFG_RST;
            dlyen_r <= LIO_DLYEN_RST;
            dly_r   <= LIO_DLY_RST;
            imask_r <= LIO_MASK_RST;
        end else begin
            if (wr_mode) begin
                mode_r <= i_bus.wdata;
            end
            if (wr_cfg) begin
                cfg_r <= i_bus.wdata[1:0];
            end
            if (wr_dlyen) begin
                dlyen_r <= i_bus.wdata;
            end
            if (wr_dly) begin
                dly_r <= i_bus.wdata[15:0];
            end
            if (wr_imask) begin
                imask_r <= i_bus.wdata[1:0];
            end
        end
    end

    // Logical outputs: each one follows user logic, and an enabled
    // falling-edge delay holds it high for the set number of shared millisecond ticks
    // after the source falls, so a short input pulse can be stretched.
    for (genvar g = 0; g < LIO_N; g++) begin : g_lo
        logic [15:0] cnt_r;
        wire         cnt_busy = (cnt_r != 16'h0000);

        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                cnt_r <= 16'h0000;
            end else if (i_lo_val[g]) begin
                cnt_r <= dly_r;
            end else if (cnt_busy && ms_tick) begin
                cnt_r <= cnt_r - 16'h0001;
            end
        end

        assign lo_nxt[g] = i_lo_val[g] | (dlyen_r[g] & cnt_busy);
    end

    // Registered output values feed functions, groups, relays and LEDs.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            lo_r <= 32'h0000_0000;
        end else begin
            lo_r <= lo_nxt;
        end
    end

    assign o_lo_val = lo_r;

    // Commands from the mimic and from software merge per input.
    assign li_set = i_mimic.set | (wr_set ? i_bus.wdata : 32'h0000_0000);
    assign li_clr = i_mimic.clr | (wr_clr ? i_bus.wdata : 32'h0000_0000);

    // Thirty-two logical input cells.
    for (genvar g = 0; g < LIO_N; g++) begin : g_li
        lio_in_cell #(
            .MS_CYCLES (MS_CYCLES)
        ) u_cell (
            .i_clk   (i_clk),
            .i_rst   (i_rst),
            .i_set   (li_set[g]),
            .i_clr   (li_clr[g]),
            .i_pulse (mode_r[g]),
            .o_state (li_val[g])
        );
    end

    assign o_li_val = li_val;

    // Change detection: rising gives ON, falling gives OFF. The request
    // vector holds output ON, output OFF, input ON, input OFF, 32 each.
    assign on_en   = cfg_r[LIO_CFG_ON];
    assign off_en  = cfg_r[LIO_CFG_OFF];
    assign lo_chg  = lo_r ^ lo_prev_r;
    assign li_chg  = li_val ^ li_prev_r;
    assign en_mask = {{LIO_N{off_en}}, {LIO_N{on_en}},
                      {LIO_N{off_en}}, {LIO_N{on_en}}};
    assign new_ev  = {li_chg & ~li_val, li_chg & li_val,
                      lo_chg & ~lo_r, lo_chg & lo_r} & en_mask;

    // One event leaves per cycle, lowest request first. A request whose
    // kind is disabled is dropped, and a new one wins over its own clear.
    assign live     = pend_r & en_mask;
    assign ev_any   = |live;
    assign sel_idx  = first_set(live);
    assign clr_vec  = ev_any ? (LIO_EV_N'(1) << sel_idx) : '0;
    assign pend_nxt = ((live & ~clr_vec) | new_ev) & en_mask;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            lo_prev_r <= 32'h0000_0000;
            li_prev_r <= 32'h0000_0000;
            pend_r    <= '0;
        end else begin
            lo_prev_r <= lo_r;
            li_prev_r <= li_val;
            pend_r    <= pend_nxt;
        end
    end

    // Event word with group, index, kind and millisecond stamp.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            evt_r <= '0;
        end else begin
            evt_r.valid <= ev_any;
            evt_r.grp   <= lio_grp_e'(sel_idx[6]);
            evt_r.idx   <= sel_idx[4:0];
            evt_r.on    <= ~sel_idx[5];
            evt_r.stamp <= stamp_r;
        end
    end

    assign o_evt = evt_r;

    // Interrupt status: sticky per group, write one to clear, set wins.
    assign ev_hit    = {ev_any & sel_idx[6], ev_any & ~sel_idx[6]};
    assign istat_nxt = (istat_r & ~(wr_istat ? i_bus.wdata[1:0] : 2'h0)) | ev_hit;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            istat_r <= 2'h0;
        end else begin
            istat_r <= istat_nxt;
        end
    end

    assign o_irq = |(istat_r & imask_r);

    // Read selection; unmapped addresses read zero.
    always_comb begin
        case (i_bus.addr)
            LIO_OFS_LO_STAT:  rd_word = lo_r;
            LIO_OFS_LI_STAT:  rd_word = li_val;
            LIO_OFS_LI_MODE:  rd_word = mode_r;
            LIO_OFS_EVT_CFG:  rd_word = {30'h0, cfg_r};
            LIO_OFS_DLY_EN:   rd_word = dlyen_r;
            LIO_OFS_DLY_MS:   rd_word = {16'h0000, dly_r};
            LIO_OFS_IRQ_STAT: rd_word = {30'h0, istat_r};
            LIO_OFS_IRQ_MASK: rd_word = {30'h0, imask_r};
            LIO_OFS_TSTAMP:   rd_word = stamp_r;
            default:          rd_word = 32'h0000_0000;
        endcase
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= i_bus.rd ? rd_word : 32'h0000_0000;
        end
    end

    assign o_rdata = rdata_r;

    // A high source shows on the output one cycle later.
    a_lo_follow:
    assert property (i_lo_val != 32'h0 |=>
        (o_lo_val & $past(i_lo_val)) == $past(i_lo_val))
    else $error("logical output did not follow its source");

    // Status reads return the output state of the strobe cycle.
    a_lo_report:
    assert property (i_bus.rd && (i_bus.addr == LIO_OFS_LO_STAT) |=>
        o_rdata == $past(lo_r))
    else $error("output status read returned wrong data");

    // Inputs are all zero at the first edge after reset.
    a_li_reboot:
    assert property ($fell(i_rst) |-> o_li_val == 32'h0)
    else $error("logical input not cleared by reset");

    // A set command drives its input to one on the next cycle.
    a_set_drives:
    assert property (li_set != 32'h0 |=>
        (o_li_val & $past(li_set)) == $past(li_set))
    else $error("set command did not raise the input");

    // A rising output zero leaves an ON event within the scan time.
    a_event_rise:
    assert property ($rose(lo_r[0]) && on_en |-> ##[1:130]
        (o_evt.valid && o_evt.on && (o_evt.idx == 5'h0)
         && (o_evt.grp == output_event_group)))
    else $error("rising output change gave no ON event");

    // Only enabled kinds of event leave the block.
    a_event_gate:
    assert property (o_evt.valid |->
        (o_evt.on ? $past(on_en) : $past(off_en)))
    else $error("disabled event kind was emitted");

    // The stamp is the running millisecond count of the selection cycle.
    a_stamp_time:
    assert property (o_evt.valid |-> (stamp_r - o_evt.stamp) <= 32'h1)
    else $error("event stamp is stale");

    // An enabled delay keeps the output high after its source falls.
    // Output four is watched, as it is the one that stretched pulses use.
    a_pulse_stretch:
    assert property ($fell(i_lo_val[4]) && dlyen_r[4] && (dly_r > 16'h1)
        && $stable(dly_r) |=> o_lo_val[4])
    else $error("falling-edge delay did not hold the output");

    // An input-group event marks its interrupt status bit.
    a_irq_cause:
    assert property (o_evt.valid && (o_evt.grp == input_event_group) |->
        istat_r[LIO_IRQ_IN])
    else $error("input event did not set its status bit");
endmodule
`default_nettype wire

// ### test/lio_far_model.sv
// Far-side model: user logic sources, mimic switch and event sink.
`timescale 1ns/10ps
`default_nettype none
module lio_far_model (
    // Clock.
    input  wire logic              i_clk,
    // Bank outputs seen by the far side.
    input  wire lio_pkg::lio_evt_s i_evt,
    input  wire logic [31:0]       i_li_val,
    // Drives into the bank.
    output logic [31:0]            o_lo_val,
    output lio_pkg::lio_cmd_s      o_mimic
);
    import lio_pkg::*;
    logic [31:0] man_r;
    logic        link_r;
    lio_evt_s    ev_q[$];

    // A user logic path from input 5 to output 4, switched in on demand.
    assign o_lo_val = man_r | ({31'h0, link_r & i_li_val[5]} << 4);

    initial begin
        man_r = 32'h0;
        link_r = 1'b0;
        o_mimic = '0;
    end

    // The sink has no back-pressure, so it takes every offered event.
    always @(posedge i_clk) begin
        if (i_evt.valid === 1'b1) begin
            ev_q.push_back(i_evt);
        end
    end

    // One-cycle set and clear command.
    task automatic command(input logic [31:0] set, input logic [31:0] clr);
        @(posedge i_clk);
        o_mimic <= {set, clr};
        @(posedge i_clk);
        o_mimic <= '0;
    endtask

    // New source value for the logical outputs.
    task automatic drive(input logic [31:0] val);
        @(posedge i_clk);
        man_r <= val;
    endtask

    // Connects or cuts the input-to-output path.
    task automatic set_link(input logic on);
        @(posedge i_clk);
        link_r <= on;
    endtask
endmodule
`default_nettype wire

// ### test/testbench.sv
// Self-checking testbench of the logical signal bank.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import lio_pkg::*;
    localparam int MS    = 20;
    localparam int PULSE = 5 * MS;

    logic        i_clk;
    logic        i_rst;
    lio_bus_s    bus;
    logic [31:0] rdata;
    logic [31:0] lo_src;
    logic [31:0] lo_val;
    lio_cmd_s    mimic;
    logic [31:0] li_val;
    lio_evt_s    evt;
    logic        irq;
    int          failures;
    int          checks;
    int          n;
    logic [31:0] s0;
    logic [31:0] s1;

    lio_bank #(.MS_CYCLES(MS)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_bus(bus), .o_rdata(rdata),
        .i_lo_val(lo_src), .o_lo_val(lo_val), .i_mimic(mimic), .o_li_val(li_val),
        .o_evt(evt), .o_irq(irq));
    lio_far_model FAR (.i_clk(i_clk), .i_evt(evt), .i_li_val(li_val), .o_lo_val(lo_src),
        .o_mimic(mimic));

    // Clock of 100 ns period.
    always #50 i_clk = ~i_clk;

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Word comparison.
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Register bus write and read.
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge i_clk);
        bus.rd <= 1'b0;
        #10;
        d = rdata;
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        rd_reg(a, d);
        cmp(d, exp, what);
    endtask

    // Bounded wait for a number of captured events.
    task automatic wait_evt(input int cnt);
        int k;
        k = 0;
        while (FAR.ev_q.size() < cnt && k < 400) begin
            @(posedge i_clk);
            k++;
        end
        if (FAR.ev_q.size() < cnt) begin
            failures++;
            $display("unexpected at %0t: event missing", $time);
            report_and_stop();
        end
    endtask

    // Takes the oldest event and compares group, index and kind.
    task automatic chk_evt(input lio_grp_e g, input logic [4:0] i, input logic on,
                           output logic [31:0] stamp);
        lio_evt_s e;
        e = FAR.ev_q.pop_front();
        stamp = e.stamp;
        cmp({25'h0, e.grp, e.idx, e.on}, {25'h0, g, i, on}, "event");
    endtask

    // Counts cycles that one logical output or logical input bit stays high.
    task automatic high_time(input logic lo, input int b, output int cnt);
        cnt = 0;
        #1;
        while ((lo ? lo_val[b] : li_val[b]) === 1'b1 && cnt < 400) begin
            cnt++;
            @(posedge i_clk);
            #1;
        end
        if (cnt == 400) begin
            failures++;
            $display("unexpected at %0t: level stuck high", $time);
            report_and_stop();
        end
    endtask

    task automatic do_reset();
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
    endtask

    // Reset values, write-only and unmapped places.
    task automatic t_reset_values();
        bus_wr(8'h3c, 32'hffff_ffff);
        chk_reg(LIO_OFS_LI_STAT, 32'h0, "li stat");
        chk_reg(LIO_OFS_LI_MODE, LIO_MODE_RST, "mode");
        chk_reg(LIO_OFS_EVT_CFG, {30'h0, LIO_CFG_RST}, "cfg");
        chk_reg(LIO_OFS_DLY_EN, LIO_DLYEN_RST, "dly en");
        chk_reg(LIO_OFS_IRQ_MASK, {30'h0, LIO_MASK_RST}, "mask");
        chk_reg(LIO_OFS_DLY_MS, {16'h0, LIO_DLY_RST}, "dly ms reset");
        chk_reg(LIO_OFS_IRQ_STAT, 32'h0, "irq stat reset");
        chk_reg(LIO_OFS_LI_SET, 32'h0, "set word");
        chk_reg(8'h3c, 32'h0, "unmapped");
        $display("test reset values done");
    endtask

    // Outputs follow sources, raise events and the interrupt.
    task automatic t_outputs();
        FAR.ev_q.delete();
        FAR.drive(32'h8000_0001);
        @(posedge i_clk);
        #1;
        cmp(lo_val, 32'h8000_0001, "output value");
        chk_reg(LIO_OFS_LO_STAT, 32'h8000_0001, "lo stat");
        wait_evt(2);
        chk_evt(output_event_group, 5'd0, 1'b1, s0);
        chk_evt(output_event_group, 5'd31, 1'b1, s0);
        chk_reg(LIO_OFS_IRQ_STAT, 32'h1, "irq stat");
        cmp({31'h0, irq}, 32'h0, "irq masked");
        bus_wr(LIO_OFS_IRQ_MASK, 32'h3);
        #1;
        cmp({31'h0, irq}, 32'h1, "irq raised");
        bus_wr(LIO_OFS_IRQ_STAT, 32'h1);
        #1;
        cmp({31'h0, irq}, 32'h0, "irq cleared");
        FAR.drive(32'h0);
        wait_evt(2);
        chk_evt(output_event_group, 5'd0, 1'b0, s0);
        chk_evt(output_event_group, 5'd31, 1'b0, s0);
        bus_wr(LIO_OFS_IRQ_STAT, 32'h3);
        $display("test outputs done");
    endtask

    // Hold mode, set against clear, register commands and restart.
    task automatic t_hold();
        FAR.ev_q.delete();
        FAR.command(32'h208, 32'h200);
        #1;
        cmp(li_val, 32'h208, "set wins");
        repeat (2 * PULSE) @(posedge i_clk);
        bus_wr(LIO_OFS_LI_SET, 32'h80);
        chk_reg(LIO_OFS_LI_STAT, 32'h288, "held");
        wait_evt(3);
        chk_evt(input_event_group, 5'd3, 1'b1, s0);
        chk_evt(input_event_group, 5'd9, 1'b1, s0);
        chk_evt(input_event_group, 5'd7, 1'b1, s0);
        chk_reg(LIO_OFS_IRQ_STAT, 32'h2, "input status");
        cmp({31'h0, irq}, 32'h1, "input irq");
        FAR.command(32'h0, 32'h8);
        bus_wr(LIO_OFS_LI_CLR, 32'h200);
        #1;
        cmp(li_val, 32'h80, "cleared");
        do_reset();
        #1;
        cmp(li_val, 32'h0, "restart clears");
        $display("test hold done");
    endtask

    // Pulse mode beside hold mode, stamps and restart of a pulse.
    task automatic t_pulse();
        FAR.ev_q.delete();
        bus_wr(LIO_OFS_LI_MODE, 32'h20);
        FAR.command(32'h60, 32'h0);
        high_time(1'b0, 5, n);
        cmp(n, PULSE, "pulse length");
        cmp(li_val, 32'h40, "hold beside pulse");
        wait_evt(3);
        chk_evt(input_event_group, 5'd5, 1'b1, s0);
        chk_evt(input_event_group, 5'd6, 1'b1, s1);
        chk_evt(input_event_group, 5'd5, 1'b0, s1);
        cmp(s1 - s0, 32'h5, "stamp spacing");
        rd_reg(LIO_OFS_TSTAMP, s0);
        repeat (PULSE - 2) @(posedge i_clk);
        rd_reg(LIO_OFS_TSTAMP, s1);
        cmp(s1 - s0, 32'h5, "stamp register");
        bus_wr(LIO_OFS_LI_CLR, 32'h40);
        FAR.command(32'h20, 32'h0);
        repeat (49) @(posedge i_clk);
        FAR.command(32'h20, 32'h0);
        high_time(1'b0, 5, n);
        cmp(n, PULSE, "restarted pulse");
        $display("test pulse done");
    endtask

    // A pulse routed to an output with off-delay outlasts the pulse.
    task automatic t_delay();
        bus_wr(LIO_OFS_DLY_EN, 32'h10);
        bus_wr(LIO_OFS_DLY_MS, 32'h2);
        chk_reg(LIO_OFS_DLY_MS, 32'h2, "dly ms");
        FAR.set_link(1'b1);
        FAR.command(32'h20, 32'h0);
        @(posedge i_clk);
        high_time(1'b1, 4, n);
        cmp({31'h0, n >= PULSE + MS}, 32'h1, "stretched");
        cmp({31'h0, n <= PULSE + 2 * MS + 2}, 32'h1, "stretch bound");
        FAR.set_link(1'b0);
        $display("test delay done");
    endtask

    // Every enable setting of the two event kinds.
    task automatic t_evt_cfg();
        repeat (10) @(posedge i_clk);
        for (int c = 0; c < 4; c++) begin
            bus_wr(LIO_OFS_EVT_CFG, c);
            FAR.ev_q.delete();
            FAR.drive(32'h4);
            FAR.drive(32'h0);
            repeat (10) @(posedge i_clk);
            cmp(FAR.ev_q.size(), (c & 1) + (c >> 1), "enabled kinds");
            if (c == 1 || c == 2) begin
                chk_evt(output_event_group, 5'd2, c == 1, s0);
            end
        end
        $display("test event enables done");
    endtask

    initial begin
        i_clk = 1'b0;
        i_rst = 1'b1;
        bus = '0;
        failures = 0;
        checks = 0;
        do_reset();
        t_reset_values();
        t_outputs();
        t_hold();
        t_pulse();
        t_delay();
        t_evt_cfg();
        report_and_stop();
    end
endmodule
`default_nettype wire
